/* File: common/nvac_pkg.sv */
// package for the nonvolatile access controller: offsets, fields, resets, timing
// assumes an apb slave on pclk at 250 MHz; nvm array modelled behind simple ports
package nvac_pkg;
    // register byte offsets
    localparam logic [11:0] OFS_CONTROL = 12'h18C;
    localparam logic [11:0] OFS_UNLOCK = 12'h18D;
    localparam logic [11:0] OFS_DATA_LO = 12'h10C;
    localparam logic [11:0] OFS_ADDR_LO = 12'h10D;
    localparam logic [11:0] OFS_DATA_HI = 12'h10E;
    localparam logic [11:0] OFS_ADDR_HI = 12'h10F;
    localparam logic [11:0] OFS_IRQ_STATUS = 12'h200;
    localparam logic [11:0] OFS_IRQ_MASK = 12'h204;
    localparam logic [11:0] OFS_STALL = 12'h208;
    // control field positions
    localparam int BIT_SPACE = 7;
    localparam int BIT_ERASE = 4;
    localparam int BIT_ERR = 3;
    localparam int BIT_WEN = 2;
    localparam int BIT_WR = 1;
    localparam int BIT_RD = 0;
    // irq bits: 0 write done, 1 read done, 2 write aborted
    localparam int IRQ_WDONE = 0;
    localparam int IRQ_RDONE = 1;
    localparam int IRQ_ABORT = 2;
    // unlock codes
    localparam logic [7:0] UNLOCK_FIRST = 8'h55;
    localparam logic [7:0] UNLOCK_SECOND = 8'hAA;
    // reset values
    localparam logic [7:0] CONTROL_RESET = 8'h00;
    localparam logic [2:0] IRQ_MASK_RESET = 3'h0;
    // timing
    localparam int WRITE_TIME_NS = 2000;
    localparam int CLK_PERIOD_NS = 4;
    localparam int WRITE_CYCLES = WRITE_TIME_NS / CLK_PERIOD_NS;
    localparam int READ_CYCLES = 2;
    localparam int STALL_INSNS = 2;
    // one bit flips on every legal transition
    typedef enum logic [1:0] {
        NVAC_IDLE = 2'h0,
        NVAC_READ = 2'h1,
        NVAC_WRITE = 2'h2
    } nvac_state_t;
endpackage : nvac_pkg

/* File: hdl/nvac_ctrl.sv */
// nonvolatile access controller top: apb registers, strobes, unlock, error flag, irq
// assumes the array is outside; ext/watchdog resets arrive as pins, abort a write
`timescale 1ns/1ps
//////////////////////////////////////////////////////////////////////////////
module nvac_ctrl (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic ext_reset_n,
    input wire logic wdt_reset,
    input wire logic [13:0] nvm_rdata,
    output logic nvm_rd,
    output logic nvm_wr,
    output logic nvm_erase,
    output logic nvm_program,
    output logic [12:0] nvm_addr,
    output logic [13:0] nvm_wdata,
    output logic core_stall,
    output logic irq
);
    logic [7:0] ctrl_reg;
    logic [7:0] data_lo_reg;
    logic [5:0] data_hi_reg;
    logic [7:0] addr_lo_reg;
    logic [4:0] addr_hi_reg;
    logic [2:0] irq_status_reg;
    logic [2:0] irq_mask_reg;
    logic [1:0] stall_cnt_reg;
    logic [1:0] rst_sync_reg;
    logic [1:0] wdt_sync_reg;
    nvac_pkg::nvac_state_t state_reg;
    logic bus_wr;
    logic wr_ctrl;
    logic armed;
    logic start_wr;
    logic start_rd;
    logic tmr_busy;
    logic tmr_done;
    logic abort;
    logic [9:0] tmr_load;
    //////////////////////////////////////////////////////////////////////////
    // bus decode: zero-wait slave
    assign bus_wr = psel && penable && pwrite;
    assign wr_ctrl = bus_wr && (paddr == nvac_pkg::OFS_CONTROL);
    assign start_wr = wr_ctrl && pwdata[nvac_pkg::BIT_WR] && ctrl_reg[nvac_pkg::BIT_WEN]
        && armed && (state_reg == nvac_pkg::NVAC_IDLE);
    // only a one starts a read
    assign start_rd = wr_ctrl && pwdata[nvac_pkg::BIT_RD] && !start_wr && (state_reg == nvac_pkg::NVAC_IDLE);
    // resets from outside pass two flops; abort on their synced level
    assign abort = (state_reg == nvac_pkg::NVAC_WRITE) && (!rst_sync_reg[1] || wdt_sync_reg[1]);
    assign tmr_load = start_wr ? 10'(nvac_pkg::WRITE_CYCLES) : 10'(nvac_pkg::READ_CYCLES);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rst_sync_reg <= 2'h3;
            wdt_sync_reg <= 2'h0;
        end else begin
            rst_sync_reg <= {rst_sync_reg[0], ext_reset_n};
            wdt_sync_reg <= {wdt_sync_reg[0], wdt_reset};
        end
    end

    nvac_unlock u_unlock (
        .pclk(pclk),
        .presetn(presetn),
        .any_wr(bus_wr),
        .unlock_wr(bus_wr && (paddr == nvac_pkg::OFS_UNLOCK)),
        .wdata(pwdata[7:0]),
        .consume(start_wr),
        .armed(armed)
    );

    nvac_timer u_timer (
        .pclk(pclk),
        .presetn(presetn),
        .start(start_wr || start_rd),
        .load(tmr_load),
        .abort(abort),
        .busy(tmr_busy),
        .done(tmr_done)
    );
    //////////////////////////////////////////////////////////////////////////
    // operation state
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_reg <= nvac_pkg::NVAC_IDLE;
        end else begin
            unique case (state_reg)
                nvac_pkg::NVAC_IDLE: begin
                    if (start_wr) begin
                        state_reg <= nvac_pkg::NVAC_WRITE;
                    end else if (start_rd) begin
                        state_reg <= nvac_pkg::NVAC_READ;
                    end
                end
                nvac_pkg::NVAC_READ: begin
                    if (tmr_done) begin
                        state_reg <= nvac_pkg::NVAC_IDLE;
                    end
                end
                nvac_pkg::NVAC_WRITE: begin
                    if (tmr_done || abort) begin
                        state_reg <= nvac_pkg::NVAC_IDLE;
                    end
                end
                default: state_reg <= nvac_pkg::NVAC_IDLE;
            endcase
        end
    end
    //////////////////////////////////////////////////////////////////////////
    // control register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_reg <= nvac_pkg::CONTROL_RESET;
        end else begin
            if (wr_ctrl) begin
                if (state_reg != nvac_pkg::NVAC_WRITE) begin
                    ctrl_reg[nvac_pkg::BIT_SPACE] <= pwdata[nvac_pkg::BIT_SPACE];
                end
                ctrl_reg[nvac_pkg::BIT_ERASE] <= pwdata[nvac_pkg::BIT_ERASE];
                ctrl_reg[nvac_pkg::BIT_WEN] <= pwdata[nvac_pkg::BIT_WEN];
            end
            if (abort) begin
                ctrl_reg[nvac_pkg::BIT_ERR] <= 1'b1;
            end else if (start_wr) begin
                ctrl_reg[nvac_pkg::BIT_ERR] <= 1'b0;
            end else if (wr_ctrl) begin
                ctrl_reg[nvac_pkg::BIT_ERR] <= pwdata[nvac_pkg::BIT_ERR];
            end
            if (start_wr) begin
                ctrl_reg[nvac_pkg::BIT_WR] <= 1'b1;
            end else if (state_reg == nvac_pkg::NVAC_WRITE && (tmr_done || abort)) begin
                ctrl_reg[nvac_pkg::BIT_WR] <= 1'b0;
            end
            if (start_rd) begin
                ctrl_reg[nvac_pkg::BIT_RD] <= 1'b1;
            end else if (state_reg == nvac_pkg::NVAC_READ && tmr_done) begin
                ctrl_reg[nvac_pkg::BIT_RD] <= 1'b0;
            end
        end
    end
    //////////////////////////////////////////////////////////////////////////
    // address and data bytes; read result lands in data bytes
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            addr_lo_reg <= 8'h00;
            addr_hi_reg <= 5'h00;
        end else if (bus_wr) begin
            if (paddr == nvac_pkg::OFS_ADDR_LO) begin
                addr_lo_reg <= pwdata[7:0];
            end
            if (paddr == nvac_pkg::OFS_ADDR_HI) begin
                addr_hi_reg <= pwdata[4:0];
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            data_lo_reg <= 8'h00;
            data_hi_reg <= 6'h00;
        end else if (state_reg == nvac_pkg::NVAC_READ && tmr_done) begin
            data_lo_reg <= nvm_rdata[7:0];
            data_hi_reg <= ctrl_reg[nvac_pkg::BIT_SPACE] ? nvm_rdata[13:8] : 6'h00;
        end else if (bus_wr) begin
            if (paddr == nvac_pkg::OFS_DATA_LO) begin
                data_lo_reg <= pwdata[7:0];
            end
            if (paddr == nvac_pkg::OFS_DATA_HI) begin
                data_hi_reg <= pwdata[5:0];
            end
        end
    end
    //////////////////////////////////////////////////////////////////////////
    // array strobes
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            nvm_rd <= 1'b0;
            nvm_wr <= 1'b0;
            nvm_erase <= 1'b0;
            nvm_program <= 1'b0;
            nvm_addr <= 13'h0000;
            nvm_wdata <= 14'h0000;
        end else begin
            nvm_rd <= start_rd;
            nvm_wr <= start_wr && !(ctrl_reg[nvac_pkg::BIT_ERASE] && ctrl_reg[nvac_pkg::BIT_SPACE]);
            nvm_erase <= start_wr && ctrl_reg[nvac_pkg::BIT_ERASE] && ctrl_reg[nvac_pkg::BIT_SPACE];
            if (start_wr || start_rd) begin
                nvm_program <= ctrl_reg[nvac_pkg::BIT_SPACE];
                nvm_addr <= {addr_hi_reg, addr_lo_reg};
                nvm_wdata <= {data_hi_reg, data_lo_reg};
            end
        end
    end
    //////////////////////////////////////////////////////////////////////////
    // core stall after program write strobe
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            stall_cnt_reg <= 2'h0;
            core_stall <= 1'b0;
        end else begin
            if (start_wr && ctrl_reg[nvac_pkg::BIT_SPACE]) begin
                stall_cnt_reg <= 2'(nvac_pkg::STALL_INSNS);
                core_stall <= 1'b1;
            end else if (stall_cnt_reg != 2'h0) begin
                stall_cnt_reg <= stall_cnt_reg - 2'h1;
                core_stall <= (stall_cnt_reg != 2'h1);
            end else begin
                core_stall <= 1'b0;
            end
        end
    end
    //////////////////////////////////////////////////////////////////////////
    // interrupts: set wins over write-one-to-clear
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_status_reg <= 3'h0;
            irq_mask_reg <= nvac_pkg::IRQ_MASK_RESET;
            irq <= 1'b0;
        end else begin
            irq_status_reg <= (irq_status_reg
                & ~((bus_wr && paddr == nvac_pkg::OFS_IRQ_STATUS) ? pwdata[2:0] : 3'h0))
                | {abort, (state_reg == nvac_pkg::NVAC_READ) && tmr_done,
                   (state_reg == nvac_pkg::NVAC_WRITE) && tmr_done};
            if (bus_wr && paddr == nvac_pkg::OFS_IRQ_MASK) begin
                irq_mask_reg <= pwdata[2:0];
            end
            irq <= |(irq_status_reg & irq_mask_reg);
        end
    end
    //////////////////////////////////////////////////////////////////////////
    // read data path
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready <= psel && !penable;
            pslverr <= 1'b0;
            prdata <= 32'h0000_0000;
            if (psel && !penable) begin
                unique case (paddr)
                    nvac_pkg::OFS_CONTROL: prdata <= {24'h0, ctrl_reg & 8'h9F};
                    nvac_pkg::OFS_DATA_LO: prdata <= {24'h0, data_lo_reg};
                    nvac_pkg::OFS_DATA_HI: prdata <= {26'h0, data_hi_reg};
                    nvac_pkg::OFS_ADDR_LO: prdata <= {24'h0, addr_lo_reg};
                    nvac_pkg::OFS_ADDR_HI: prdata <= {27'h0, addr_hi_reg};
                    nvac_pkg::OFS_IRQ_STATUS: prdata <= {29'h0, irq_status_reg};
                    nvac_pkg::OFS_IRQ_MASK: prdata <= {29'h0, irq_mask_reg};
                    nvac_pkg::OFS_STALL: prdata <= {30'h0, tmr_busy, core_stall};
                    nvac_pkg::OFS_UNLOCK: prdata <= 32'h0000_0000;
                    default: pslverr <= 1'b1;
                endcase
            end
        end
    end
    //////////////////////////////////////////////////////////////////////////
    // checks
    // strobe set on start
    property p_wr_set;
        @(posedge pclk) disable iff (!presetn) start_wr |=> ctrl_reg[nvac_pkg::BIT_WR];
    endproperty
    a_wr_set: assert property (p_wr_set) else $error("write strobe not set");
    property p_gate;
        @(posedge pclk) disable iff (!presetn)
            (nvm_wr || nvm_erase) |-> $past(ctrl_reg[nvac_pkg::BIT_WEN] && armed);
    endproperty
    a_gate: assert property (p_gate) else $error("write without enable");
    property p_space;
        @(posedge pclk) disable iff (!presetn)
            (state_reg == nvac_pkg::NVAC_WRITE) |=> $stable(ctrl_reg[nvac_pkg::BIT_SPACE]);
    endproperty
    a_space: assert property (p_space) else $error("space changed mid write");
    property p_err;
        @(posedge pclk) disable iff (!presetn) abort |=> ctrl_reg[nvac_pkg::BIT_ERR];
    endproperty
    a_err: assert property (p_err) else $error("error flag missed");
    property p_rd;
        @(posedge pclk) disable iff (!presetn) start_rd |=> ##[1:4] !ctrl_reg[nvac_pkg::BIT_RD];
    endproperty
    a_rd: assert property (p_rd) else $error("read strobe stuck");
    sequence s_pwr;
        start_wr && ctrl_reg[nvac_pkg::BIT_SPACE];
    endsequence
    property p_stall;
        @(posedge pclk) disable iff (!presetn) s_pwr |=> core_stall [*2] ##1 !core_stall;
    endproperty
    a_stall: assert property (p_stall) else $error("stall length wrong");
    property p_erase;
        @(posedge pclk) disable iff (!presetn)
            s_pwr and ctrl_reg[nvac_pkg::BIT_ERASE] |=> nvm_erase && !nvm_wr;
    endproperty
    a_erase: assert property (p_erase) else $error("erase not issued");
    property p_space_sel;
        @(posedge pclk) disable iff (!presetn)
            (start_wr || start_rd) |=> nvm_program == $past(ctrl_reg[nvac_pkg::BIT_SPACE]);
    endproperty
    a_space_sel: assert property (p_space_sel) else $error("wrong memory space");
endmodule : nvac_ctrl

/* File: hdl/nvac_timer.sv */
// down-counter timing one nvm operation; done pulses when it runs out
// assumes start only while idle
`timescale 1ns/1ps
module nvac_timer (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic start,
    input wire logic [9:0] load,
    input wire logic abort,
    output logic busy,
    output logic done
);
    logic [9:0] cnt_reg;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_reg <= 10'h000;
            busy <= 1'b0;
            done <= 1'b0;
        end else begin
            done <= 1'b0;
            if (abort) begin
                busy <= 1'b0;
                cnt_reg <= 10'h000;
            end else if (start) begin
                busy <= 1'b1;
                cnt_reg <= load;
            end else if (busy) begin
                if (cnt_reg == 10'h001) begin
                    busy <= 1'b0;
                    done <= 1'b1;
                end
                cnt_reg <= cnt_reg - 10'h001;
            end
        end
    end
endmodule : nvac_timer

/* File: hdl/nvac_unlock.sv */
// two-step unlock tracker: 0x55 then 0xAA, consecutive unlock writes
// assumes bus write strobes are single-cycle pulses on pclk
`timescale 1ns/1ps
module nvac_unlock (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic any_wr,
    input wire logic unlock_wr,
    input wire logic [7:0] wdata,
    input wire logic consume,
    output logic armed
);
    logic first_reg;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            first_reg <= 1'b0;
            armed <= 1'b0;
        end else if (consume) begin
            first_reg <= 1'b0;
            armed <= 1'b0;
        end else if (unlock_wr) begin
            first_reg <= (wdata == nvac_pkg::UNLOCK_FIRST);
            armed <= first_reg && (wdata == nvac_pkg::UNLOCK_SECOND);
        end else if (any_wr) begin
            // other writes break the sequence but keep a completed unlock
            first_reg <= 1'b0;
        end
    end
endmodule : nvac_unlock

/* File: tb/nvac_ctrl_bench.sv */
// bench for nvac_ctrl: apb scenarios on unlock, writes, erase, reads, abort, irq
// assumes nvac_pkg compiled first; array read data is a fixed word on nvm_rdata
`timescale 1ns/1ps
module nvac_ctrl_bench;
    localparam logic [11:0] A_CTL = nvac_pkg::OFS_CONTROL;
    localparam logic [11:0] A_ULK = nvac_pkg::OFS_UNLOCK;
    localparam logic [11:0] A_DLO = nvac_pkg::OFS_DATA_LO;
    localparam logic [11:0] A_ALO = nvac_pkg::OFS_ADDR_LO;
    localparam logic [11:0] A_DHI = nvac_pkg::OFS_DATA_HI;
    localparam logic [11:0] A_AHI = nvac_pkg::OFS_ADDR_HI;
    localparam logic [11:0] A_IST = nvac_pkg::OFS_IRQ_STATUS;
    localparam logic [11:0] A_IMK = nvac_pkg::OFS_IRQ_MASK;
    localparam logic [7:0] SP = 8'h01 << nvac_pkg::BIT_SPACE;
    localparam logic [7:0] ER = 8'h01 << nvac_pkg::BIT_ERASE;
    localparam logic [7:0] WEN = 8'h01 << nvac_pkg::BIT_WEN;
    localparam logic [7:0] WR = 8'h01 << nvac_pkg::BIT_WR;
    localparam logic [7:0] RD = 8'h01 << nvac_pkg::BIT_RD;
    localparam int WC = nvac_pkg::WRITE_CYCLES;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h00000000;
    logic [31:0] prdata;
    logic pready, pslverr, nvm_rd, nvm_wr, nvm_erase, nvm_program, core_stall, irq;
    logic ext_reset_n = 1'b1;
    logic wdt_reset = 1'b0;
    logic [13:0] nvm_rdata = 14'h2A5B;
    logic [12:0] nvm_addr, last_addr;
    logic [13:0] nvm_wdata, last_wdata;
    logic last_prog;
    logic [31:0] rdat;
    logic rerr;
    int mismatches = 0;
    int num_checks = 0;
    int n_rd = 0, n_wr = 0, n_erase = 0, n_stall = 0, cyc = 0;

    always #2 pclk = ~pclk;

    nvac_ctrl i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .ext_reset_n(ext_reset_n), .wdt_reset(wdt_reset), .nvm_rdata(nvm_rdata), .nvm_rd(nvm_rd),
        .nvm_wr(nvm_wr), .nvm_erase(nvm_erase), .nvm_program(nvm_program), .nvm_addr(nvm_addr),
        .nvm_wdata(nvm_wdata), .core_stall(core_stall), .irq(irq));

    // pulse counters; a stuck pulse shows up as an extra count
    always @(posedge pclk) begin
        cyc <= cyc + 1;
        if (nvm_wr === 1'b1) n_wr <= n_wr + 1;
        if (nvm_rd === 1'b1) n_rd <= n_rd + 1;
        if (nvm_erase === 1'b1) n_erase <= n_erase + 1;
        if (core_stall === 1'b1) n_stall <= n_stall + 1;
        if (nvm_wr === 1'b1 || nvm_rd === 1'b1) begin
            last_addr <= nvm_addr;
            last_wdata <= nvm_wdata;
            last_prog <= nvm_program;
        end
    end
    //////////////////////////////////////////////////////////////////////////////
    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        num_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask : check

    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : report_and_stop

    // request held until pready is seen high at a rising edge
    task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        rdat = prdata;
        rerr = pslverr;
        if (pready !== 1'b1) check("pready", 32'h1, 32'h0);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : xfer

    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        xfer(1'b1, a, {24'h000000, d});
    endtask : wr

    task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp, input string what);
        xfer(1'b0, a, 32'h00000000);
        check(what, exp, rdat);
    endtask : rd_chk

    task automatic irq_is(input logic exp);
        repeat (3) @(posedge pclk);
        check("irq", {31'h0, exp}, {31'h0, irq});
    endtask : irq_is

    // gate, space and erase land before the unlock; the strobe write sees them
    task automatic unlock_go(input logic [7:0] ctl);
        wr(A_CTL, ctl & ~WR);
        wr(A_ULK, nvac_pkg::UNLOCK_FIRST);
        wr(A_ULK, nvac_pkg::UNLOCK_SECOND);
        wr(A_CTL, ctl);
    endtask : unlock_go

    task automatic wait_idle;
        for (int i = 0; i < 400; i++) begin
            xfer(1'b0, A_CTL, 32'h00000000);
            if (rdat[nvac_pkg::BIT_WR] === 1'b0) break;
        end
        check("write strobe cleared", 32'h0, {31'h0, rdat[nvac_pkg::BIT_WR]});
    endtask : wait_idle
    //////////////////////////////////////////////////////////////////////////////
    task automatic t_reset;
        rd_chk(A_CTL, {24'h000000, nvac_pkg::CONTROL_RESET}, "control after reset");
        rd_chk(A_IMK, {29'h0, nvac_pkg::IRQ_MASK_RESET}, "mask after reset");
        check("irq after reset", 32'h0, {31'h0, irq});
        xfer(1'b1, 12'h18E, 32'h00000000);
        check("unmapped write error", 32'h1, {31'h0, rerr});
        xfer(1'b0, 12'h300, 32'h00000000);
        check("unmapped read error", 32'h1, {31'h0, rerr});
        wr(A_IMK, 8'h05);
    endtask : t_reset

    task automatic t_refuse;
        int n0;
        n0 = n_wr;
        wr(A_CTL, SP | WEN | WR);
        wr(A_ULK, nvac_pkg::UNLOCK_FIRST);
        wr(A_ALO, 8'h00);
        wr(A_ULK, nvac_pkg::UNLOCK_SECOND);
        wr(A_CTL, SP | WEN | WR);
        unlock_go(SP | WR);
        repeat (4) @(posedge pclk);
        check("refused write starts", n0, n_wr);
        rd_chk(A_CTL, {24'h000000, SP}, "strobe stays clear");
    endtask : t_refuse

    task automatic t_abort;
        int t0;
        for (int k = 0; k < 2; k++) begin
            unlock_go(SP | WEN | WR);
            t0 = cyc;
            repeat (20) @(posedge pclk);
            if (k == 0) ext_reset_n <= 1'b0;
            else wdt_reset <= 1'b1;
            repeat (4) @(posedge pclk);
            ext_reset_n <= 1'b1;
            wdt_reset <= 1'b0;
            wait_idle();
            check("cut short", 32'h1, {31'h0, (cyc - t0) < WC});
            check("error flag", 32'h1, {31'h0, rdat[nvac_pkg::BIT_ERR]});
            rd_chk(A_IST, 32'h4, "abort status") ;
            irq_is(1'b1);
            wr(A_IST, 8'h07);
            irq_is(1'b0);
        end
    endtask : t_abort

    task automatic t_erase;
        int e0;
        e0 = n_erase;
        wr(A_AHI, 8'h01);
        wr(A_ALO, 8'h00);
        unlock_go(SP | ER | WEN | WR);
        wait_idle();
        check("row erase pulse", e0 + 1, n_erase);
        check("error flag clear", 32'h0, {31'h0, rdat[nvac_pkg::BIT_ERR]});
        wr(A_IST, 8'h07);
    endtask : t_erase

    task automatic t_write(input logic s);
        int t0, n0, s0, e0;
        logic [7:0] sp;
        logic [13:0] w14;
        sp = s ? SP : 8'h00;
        wr(A_AHI, 8'h01);
        for (int w = 0; w < (s ? 4 : 1); w++) begin
            w14 = {6'h25, 8'(8'hC0 + w)};
            wr(A_ALO, 8'(8'h04 + w));
            wr(A_DLO, w14[7:0]);
            wr(A_DHI, 8'h25);
            n0 = n_wr;
            s0 = n_stall;
            e0 = n_erase;
            unlock_go(sp | WEN | WR);
            t0 = cyc;
            wr(A_CTL, WEN | (sp ^ SP));
            rd_chk(A_CTL, {24'h000000, sp | WEN | WR}, "space and strobe held");
            wait_idle();
            check("write time", 32'h1, {31'h0, (cyc - t0) >= WC - 4 && (cyc - t0) <= WC + 8});
            check("one array write", n0 + 1, n_wr);
            check("no erase", e0, n_erase);
            check("space", {31'h0, s}, {31'h0, last_prog});
            check("array address", 32'h0104 + w, {19'h0, last_addr});
            check("word low", {24'h0, w14[7:0]}, {24'h0, last_wdata[7:0]});
            if (s) check("word", {18'h0, w14}, {18'h0, last_wdata});
            check("stall cycles", s0 + (s ? nvac_pkg::STALL_INSNS : 0), n_stall);
            irq_is(1'b1);
            wr(A_IST, 8'h01);
            irq_is(1'b0);
        end
        wr(A_CTL, sp);
    endtask : t_write

    task automatic t_read;
        int r0;
        logic [7:0] sp;
        for (int s = 0; s < 2; s++) begin
            sp = (s == 1) ? SP : 8'h00;
            r0 = n_rd;
            wr(A_ALO, 8'h34);
            // space is taken from the register at the start edge
            wr(A_CTL, sp);
            wr(A_CTL, sp | RD);
            // strobe clears three edges after the start edge
            repeat (2) @(posedge pclk);
            rd_chk(A_CTL, {24'h000000, sp}, "read strobe cleared");
            check("one array read", r0 + 1, n_rd);
            check("read space", s, {31'h0, last_prog});
            rd_chk(A_DLO, 32'h5B, "read low byte");
            rd_chk(A_DHI, (s == 1) ? 32'h2A : 32'h00, "read high byte");
            wr(A_CTL, sp);
            repeat (4) @(posedge pclk);
            check("zero starts nothing", r0 + 1, n_rd);
            irq_is(1'b0);
        end
        wr(A_IMK, 8'h07);
        irq_is(1'b1);
        wr(A_IST, 8'h02);
        irq_is(1'b0);
    endtask : t_read
    //////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        t_reset();
        t_refuse();
        t_abort();
        t_erase();
        t_write(1'b0);
        t_write(1'b1);
        t_read();
        report_and_stop();
    end

    // hang guard well beyond the few thousand cycles the tests need
    initial begin
        repeat (20000) @(posedge pclk);
        mismatches++;
        report_and_stop();
    end
endmodule : nvac_ctrl_bench
